// ---- tb/user_program_request_queue_tb.sv ----
/*
  Self-checking bench for the request queue: registers over AXI4-Lite,
  request capture, fill and overflow, flush, counters and interrupt.
  Assumes upq_consts.svh on the include path and upq_pkg compiled first.
*/
`default_nettype none
`include "upq_consts.svh"
module user_program_request_queue_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] aPc = `UPQ_OFF_PROG_ADDR;
  localparam logic [11:0] aUa = `UPQ_OFF_UNIF_ADDR;
  localparam logic [11:0] aUl = `UPQ_OFF_UNIF_LEN;
  localparam logic [11:0] aCs = `UPQ_OFF_CTRL_STAT;
  localparam logic [11:0] aRv = `UPQ_OFF_MEM_RSV;
  localparam logic [11:0] aIs = `UPQ_OFF_IRQ_STAT;
  localparam logic [11:0] aIm = `UPQ_OFF_IRQ_MASK;
  logic mclk, srst, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic reqValid, popReq, progDone, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [4:0] userMemReserve;
  upq_pkg::upq_req_t reqHead;
  int errors, testsRun;
  logic [1:0] rs;

  ////////////////////////////////////////////////////////////////////////////
  // Response channels always ready, full-word strobes only
  upq_request_queue u_dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .reqHead(reqHead), .reqValid(reqValid), .popReq(popReq),
    .progDone(progDone), .userMemReserve(userMemReserve), .irq(irq));

  // Clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready sampled mid-cycle, so the handshake edge is the next rising one;
  // no local limit, only the watchdog ends a wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic hA, hW, dA, dW;
    dA = 1'b0;
    dW = 1'b0;
    hA = 1'b0;
    hW = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(dA && dW)) begin
      @(negedge mclk);
      hA = awvalid && awready;
      hW = wvalid && wready;
      @(posedge mclk);
      if (hA) begin
        awvalid <= 1'b0;
        dA = 1'b1;
      end
      if (hW) begin
        wvalid <= 1'b0;
        dW = 1'b1;
      end
    end
    hA = 1'b0;
    while (!hA) begin
      @(negedge mclk);
      hA = bvalid;
      r = bresp;
      @(posedge mclk);
    end
  endtask

  // Address held to its taking edge, data taken in the cycle it stands
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    h = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!h) begin
      @(negedge mclk);
      h = arready;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge mclk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Registered outputs follow, then are looked at mid-cycle
  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  // One-cycle pop pulse, driven on rising edges
  task automatic pop;
    @(posedge mclk);
    popReq <= 1'b1;
    @(posedge mclk);
    popReq <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rdChk(aUl, 32'h0000_0000, 2'b00);
    rdChk(aCs, 32'h0000_0000, 2'b00);
    rdChk(aRv, 32'h0000_0000, 2'b00);
    chk({30'h0, reqValid, irq}, 32'h0000_0000);
  endtask

  // Length over 1023 and at 1023 travel with their requests
  task automatic tUnif;
    wr(aUa, 32'h8000_0040, rs);
    chk({30'h0, rs}, {30'h0, `UPQ_RESP_OKAY});
    wr(aUl, 32'h0000_0400, rs);
    wr(aPc, 32'h0000_1000, rs);
    settle;
    chk({19'h0, reqHead.unifUnlimited, reqHead.unifLen}, 32'h0000_1400);
    chk(reqHead.unifAddr, 32'h8000_0040);
    rdChk(aUl, 32'h0000_0400, 2'b00);
    rdChk(aUa, 32'h8000_0040, 2'b00);
    wr(aUl, 32'h0000_03FF, rs);
    wr(aPc, 32'h0000_2000, rs);
    pop;
    settle;
    chk(reqHead.progAddr, 32'h0000_2000);
    chk({19'h0, reqHead.unifUnlimited, reqHead.unifLen}, 32'h0000_03FF);
    pop;
    settle;
    chk({31'h0, reqValid}, 32'h0000_0000);
    rdChk(aCs, 32'h0000_0200, 2'b00);
  endtask

  // Overflow, requests ignored under error, error clear, flush, irq mask
  // (a mask bit of one lets its status bit through)
  task automatic tFull;
    wr(aCs, 32'h0000_0101, rs);
    for (int i = 0; i < 16; i++) wr(aPc, 32'h0000_3000 + 32'(i), rs);
    rdChk(aCs, 32'h0000_1010, 2'b00);
    wr(aIm, 32'h0000_0001, rs);
    wr(aPc, 32'h0000_4000, rs);
    rdChk(aCs, 32'h0000_1190, 2'b00);
    rdChk(aIs, 32'h0000_0001, 2'b00);
    settle;
    chk({31'h0, irq}, 32'h0000_0001);
    pop;
    wr(aPc, 32'h0000_5000, rs);
    rdChk(aCs, 32'h0000_128F, 2'b00);
    wr(aIm, 32'h0000_0000, rs);
    settle;
    chk({31'h0, irq}, 32'h0000_0000);
    wr(aIs, 32'h0000_0001, rs);
    wr(aIm, 32'h0000_0001, rs);
    rdChk(aIs, 32'h0000_0000, 2'b00);
    settle;
    chk({31'h0, irq}, 32'h0000_0000);
    wr(aCs, 32'h0000_0080, rs);
    rdChk(aCs, 32'h0000_120F, 2'b00);
    settle;
    chk(reqHead.progAddr, 32'h0000_3001);
    wr(aCs, 32'h0000_0001, rs);
    rdChk(aCs, 32'h0000_1200, 2'b00);
    chk({31'h0, reqValid}, 32'h0000_0000);
    wr(aPc, 32'h0000_6000, rs);
    rdChk(aCs, 32'h0000_1301, 2'b00);
    pop;
    rdChk(aCs, 32'h0000_1300, 2'b00);
  endtask

  // Completed count, its clear, and wrap past 255
  task automatic tDone;
    progDone <= 1'b1;
    repeat (3) @(posedge mclk);
    progDone <= 1'b0;
    rdChk(aCs, 32'h0003_1300, 2'b00);
    rdChk(aIs, 32'h0000_0002, 2'b00);
    wr(aCs, 32'h0001_0000, rs);
    rdChk(aCs, 32'h0000_1300, 2'b00);
    rdChk(aCs, 32'h0000_1300, 2'b00);
    progDone <= 1'b1;
    repeat (257) @(posedge mclk);
    progDone <= 1'b0;
    rdChk(aCs, 32'h0001_1300, 2'b00);
  endtask

  // Reservation setting and refused accesses
  task automatic tMisc;
    wr(aRv, 32'h0000_001F, rs);
    settle;
    chk({27'h0, userMemReserve}, 32'h0000_001F);
    rdChk(aRv, 32'h0000_001F, 2'b00);
    wr(12'h01C, 32'h0000_0001, rs);
    chk({30'h0, rs}, {30'h0, `UPQ_RESP_SLVERR});
    rdChk(aPc, 32'h0000_0000, 2'b10);
    rdChk(12'h00E, 32'h0000_0000, 2'b10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (errors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    stop_test;
  end

  initial begin
    errors = 0; testsRun = 0;
    srst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0000_0000;
    popReq = 1'b0; progDone = 1'b0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    tReset;
    tUnif;
    tFull;
    tDone;
    tMisc;
    stop_test;
  end
endmodule
`default_nettype wire

// ---- verilog/upq_consts.svh ----
/*
  Constants for the user program request queue: register byte offsets,
  field positions, widths, response codes and limits.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef UPQ_CONSTS_SVH
`define UPQ_CONSTS_SVH
`define UPQ_OFF_PROG_ADDR 12'h000
`define UPQ_OFF_UNIF_ADDR 12'h004
`define UPQ_OFF_UNIF_LEN 12'h008
`define UPQ_OFF_CTRL_STAT 12'h00C
`define UPQ_OFF_MEM_RSV 12'h010
`define UPQ_OFF_IRQ_STAT 12'h014
`define UPQ_OFF_IRQ_MASK 12'h018
`define UPQ_UNIF_LEN_W 12
`define UPQ_UNIF_LEN_MAX 12'h03FF
`define UPQ_CC_LSB 16
`define UPQ_CM_LSB 8
`define UPQ_ERR_BIT 7
`define UPQ_FLUSH_BIT 0
`define UPQ_DEPTH_W 6
`define UPQ_RSV_W 5
`define UPQ_QUEUE_DEPTH 16
`define UPQ_RESP_OKAY 2'b00
`define UPQ_RESP_SLVERR 2'b10
`define UPQ_IRQ_ERR 0
`define UPQ_IRQ_DONE 1
`define UPQ_IRQ_W 2
`endif

// ---- verilog/upq_pkg.sv ----
/*
  Types for the user program request queue.
  Assumes upq_consts.svh is on the include path.
*/
`default_nettype none
`include "upq_consts.svh"
package upq_pkg;
  // One queued run request
  typedef struct packed {
    logic [31:0] progAddr;
    logic [31:0] unifAddr;
    logic [11:0] unifLen;
    logic unifUnlimited;
  } upq_req_t;

  // Write access state
  typedef enum logic [1:0] {
    UPQ_W_IDLE = 2'b00,
    UPQ_W_RESP = 2'b01
  } upq_wstate_t;
endpackage
`default_nettype wire

// ---- verilog/upq_request_queue.sv ----
/*
  User program request queue with AXI4-Lite register slave, interrupt
  status/mask and a 16-deep request store drained by the scheduler.
  Assumes one clock mclk, synchronous active-high reset srst, and a
  scheduler that pops with popReq when reqValid is high.
*/
// Design decisions made here: the address map and register access over AXI4-Lite.
`default_nettype none
`include "upq_consts.svh"

// Summary of operation
// - Hold 12-bit uniforms length, reset zero; zero means no uniforms stream.
// - Length above 1023 marks the next request's uniforms stream unlimited.
// - Uniforms length is captured with the request as its maximum length.
// - Eight-bit completed-program count wraps at 256, read in bits 23:16.
// - Status write with bit 16 set zeroes the completed count.
// - Requests-made count increments on every request, even when full or error.
// - Status write with bit 8 set zeroes the requests-made count.
// - Request while full sets sticky error; writing one to bit 7 clears it.
// - Six-bit field reports requests currently waiting in the queue.
// - Status write with bit 0 set discards all pending requests.
// - Hold five-bit user memory reservation in 256-byte units.
// - Writing the program address queues a request with current uniforms.
// - Queue holds at most 16 entries; a request when full is dropped.
// - While the error flag is set every new request is ignored.
module upq_request_queue #(
  parameter int DEPTH = `UPQ_QUEUE_DEPTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output upq_pkg::upq_req_t reqHead,
  output logic reqValid,
  input wire logic popReq,
  input wire logic progDone,
  output logic [`UPQ_RSV_W-1:0] userMemReserve,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [31:0] unifAddr_r;
  logic [`UPQ_UNIF_LEN_W-1:0] unifLen_r;
  logic [7:0] doneCount_r;
  logic [7:0] madeCount_r;
  logic queueErr_r;
  logic [`UPQ_DEPTH_W-1:0] depth_r;
  logic [`UPQ_IRQ_W-1:0] irqStat_r;
  logic [`UPQ_IRQ_W-1:0] irqMask_r;
  upq_pkg::upq_req_t store_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wrPtr_r;
  logic [$clog2(DEPTH)-1:0] rdPtr_r;

  ////////////////////////////////////////////////////////////////////////
  // Write channel: both address and data held until both present
  logic [11:0] awAddr_r;
  logic awHave_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHave_r;
  upq_pkg::upq_wstate_t wState_r;
  logic wrFire;
  logic [31:0] wrMask;

  assign wrFire = awHave_r && wHave_r && (wState_r == upq_pkg::UPQ_W_IDLE);
  assign wrMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};

  // Accept each channel independently, one write in flight
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 12'h000;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHave_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (wrFire) begin
        awHave_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (wrFire) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // Response follows the register update; unmapped gets SLVERR
  always_ff @(posedge mclk) begin
    if (srst) begin
      wState_r <= upq_pkg::UPQ_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UPQ_RESP_OKAY;
    end else begin
      case (wState_r)
        upq_pkg::UPQ_W_IDLE: begin
          if (wrFire) begin
            wState_r <= upq_pkg::UPQ_W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_r > `UPQ_OFF_IRQ_MASK || awAddr_r[1:0] != 2'b00)
                           ? `UPQ_RESP_SLVERR : `UPQ_RESP_OKAY;
          end
        end
        upq_pkg::UPQ_W_RESP: begin
          if (s_axi_bready) begin
            wState_r <= upq_pkg::UPQ_W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wState_r <= upq_pkg::UPQ_W_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded write strobes
  logic wrProg;
  logic wrCs;
  logic [31:0] csBits;
  assign wrProg = wrFire && (awAddr_r == `UPQ_OFF_PROG_ADDR);
  assign wrCs = wrFire && (awAddr_r == `UPQ_OFF_CTRL_STAT);
  assign csBits = wData_r & wrMask;

  // Setting registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      unifAddr_r <= 32'h0000_0000;
      unifLen_r <= 12'h000;
      userMemReserve <= 5'h00;
      irqMask_r <= 2'h0;
    end else if (wrFire) begin
      if (awAddr_r == `UPQ_OFF_UNIF_ADDR)
        unifAddr_r <= (unifAddr_r & ~wrMask) | csBits;
      if (awAddr_r == `UPQ_OFF_UNIF_LEN)
        unifLen_r <= (unifLen_r & ~wrMask[11:0]) | csBits[11:0];
      // Idle-only use is software's duty; hardware does not lock it
      if (awAddr_r == `UPQ_OFF_MEM_RSV)
        userMemReserve <= (userMemReserve & ~wrMask[4:0]) | csBits[4:0];
      if (awAddr_r == `UPQ_OFF_IRQ_MASK)
        irqMask_r <= (irqMask_r & ~wrMask[1:0]) | csBits[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue push/pop
  logic isFull;
  logic doPush;
  logic doPop;
  logic doFlush;
  upq_pkg::upq_req_t newReq;
  assign isFull = (depth_r == DEPTH[`UPQ_DEPTH_W-1:0]);
  assign doFlush = wrCs && csBits[`UPQ_FLUSH_BIT];
  assign doPush = wrProg && !isFull && !queueErr_r;
  assign doPop = popReq && (depth_r != '0) && !doFlush;
  always_comb begin
    newReq.progAddr = wData_r;
    newReq.unifAddr = unifAddr_r;
    newReq.unifLen = unifLen_r;
    newReq.unifUnlimited = (unifLen_r > `UPQ_UNIF_LEN_MAX);
  end

  // Storage; no reset needed for data
  always_ff @(posedge mclk) begin
    if (doPush)
      store_r[wrPtr_r] <= newReq;
  end

  // Pointers and depth
  always_ff @(posedge mclk) begin
    if (srst || doFlush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      depth_r <= '0;
    end else begin
      if (doPush)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (doPush && !doPop)
        depth_r <= depth_r + 1'b1;
      else if (doPop && !doPush)
        depth_r <= depth_r - 1'b1;
    end
  end

  // Registered head view for the scheduler
  always_ff @(posedge mclk) begin
    if (srst) begin
      reqValid <= 1'b0;
      reqHead <= '0;
    end else begin
      reqValid <= 1'b0;
      reqHead <= '0;
      if (depth_r != '0 && !doPop && !doFlush) begin
        reqValid <= 1'b1;
        reqHead <= store_r[rdPtr_r];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters and sticky error; counter clears beat counting, error set beats clear
  logic errSet;
  assign errSet = wrProg && isFull;
  always_ff @(posedge mclk) begin
    if (srst) begin
      doneCount_r <= 8'h00;
      madeCount_r <= 8'h00;
      queueErr_r <= 1'b0;
    end else begin
      if (wrCs && csBits[`UPQ_CC_LSB])
        doneCount_r <= 8'h00;
      else if (progDone)
        doneCount_r <= doneCount_r + 8'h01;
      if (wrCs && csBits[`UPQ_CM_LSB])
        madeCount_r <= 8'h00;
      else if (wrProg)
        madeCount_r <= madeCount_r + 8'h01;
      if (errSet)
        queueErr_r <= 1'b1;
      else if (wrCs && csBits[`UPQ_ERR_BIT])
        queueErr_r <= 1'b0;
    end
  end

  // Interrupt status: error and completion events, write one to clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStat_r <= 2'h0;
      irq <= 1'b0;
    end else begin
      for (int i = 0; i < `UPQ_IRQ_W; i++) begin
        if ((i == `UPQ_IRQ_ERR && errSet) || (i == `UPQ_IRQ_DONE && progDone))
          irqStat_r[i] <= 1'b1;
        else if (wrFire && awAddr_r == `UPQ_OFF_IRQ_STAT && csBits[i])
          irqStat_r[i] <= 1'b0;
      end
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel: one-cycle turnaround, reserved bits read zero
  logic [31:0] rdWord;
  always_comb begin
    rdWord = 32'h0000_0000;
    case (s_axi_araddr)
      `UPQ_OFF_UNIF_ADDR: rdWord = unifAddr_r;
      `UPQ_OFF_UNIF_LEN: rdWord = {20'h0_0000, unifLen_r};
      `UPQ_OFF_CTRL_STAT: rdWord = {8'h00, doneCount_r, madeCount_r, queueErr_r,
                                     1'b0, depth_r};
      `UPQ_OFF_MEM_RSV: rdWord = {27'h000_0000, userMemReserve};
      `UPQ_OFF_IRQ_STAT: rdWord = {30'h0000_0000, irqStat_r};
      `UPQ_OFF_IRQ_MASK: rdWord = {30'h0000_0000, irqMask_r};
      default: rdWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UPQ_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        // Program address is write-only, so it answers with an error
        s_axi_rresp <= (s_axi_araddr == `UPQ_OFF_PROG_ADDR ||
                        s_axi_araddr > `UPQ_OFF_IRQ_MASK || s_axi_araddr[1:0] != 2'b00)
                       ? `UPQ_RESP_SLVERR : `UPQ_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence fullReq;
    wrProg && isFull;
  endsequence

  chk_full_sets_err: assert property (@(posedge mclk) disable iff (srst)
    fullReq |=> queueErr_r) else $error("full request did not set error");
  chk_err_blocks_push: assert property (@(posedge mclk) disable iff (srst)
    wrProg && queueErr_r && !popReq |=> depth_r == $past(depth_r))
    else $error("request accepted while error set");
  chk_made_counts: assert property (@(posedge mclk) disable iff (srst)
    wrProg && !wrCs |=> madeCount_r == $past(madeCount_r) + 8'h01)
    else $error("request count did not advance");
  chk_depth_bound: assert property (@(posedge mclk) disable iff (srst)
    depth_r <= DEPTH[`UPQ_DEPTH_W-1:0]) else $error("depth above capacity");
  chk_flush_empties: assert property (@(posedge mclk) disable iff (srst)
    doFlush |=> depth_r == '0 ##1 !reqValid) else $error("flush left entries");
  chk_done_clear: assert property (@(posedge mclk) disable iff (srst)
    wrCs && csBits[`UPQ_CC_LSB] |=> doneCount_r == 8'h00)
    else $error("completed count not cleared");
  chk_made_clear: assert property (@(posedge mclk) disable iff (srst)
    wrCs && csBits[`UPQ_CM_LSB] |=> madeCount_r == 8'h00)
    else $error("request count not cleared");
  chk_push_depth: assert property (@(posedge mclk) disable iff (srst)
    doPush && !doPop |=> depth_r == $past(depth_r) + 1'b1)
    else $error("depth did not rise on accept");
  chk_unlimited_flag: assert property (@(posedge mclk) disable iff (srst)
    doPush && depth_r == '0 && !popReq |=> ##1 reqHead.unifUnlimited == $past(unifLen_r, 2) > 12'h3FF)
    else $error("unlimited flag wrong");
  chk_irq_level: assert property (@(posedge mclk) disable iff (srst)
    fullReq ##1 irqMask_r[`UPQ_IRQ_ERR] |=> irq) else $error("masked error gave no irq");
endmodule
`default_nettype wire
